//--- src/ath_pkg.sv
// constants shared by the terminal configuration and status register logic
package ath_pkg;

  localparam int unsigned BUS_W = 16;
  localparam int unsigned STAT_W = 9;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned LVL_W = 6;
  localparam int unsigned DIV_W = 7;
  localparam int unsigned SYNC_N = 3;

  // configuration word bit positions
  localparam int unsigned CFG_RX1_RATE = 0;
  localparam int unsigned CFG_LABEL_MEM = 1;
  localparam int unsigned CFG_RX1_LABEL_EN = 2;
  localparam int unsigned CFG_RX2_LABEL_EN = 3;
  localparam int unsigned CFG_TX_PARITY_EN = 4;
  localparam int unsigned CFG_LOOPBACK_N = 5;
  localparam int unsigned CFG_RX1_DEC_EN = 6;
  localparam int unsigned CFG_RX1_BIT9 = 7;
  localparam int unsigned CFG_RX1_BIT10 = 8;
  localparam int unsigned CFG_RX2_DEC_EN = 9;
  localparam int unsigned CFG_RX2_BIT9 = 10;
  localparam int unsigned CFG_RX2_BIT10 = 11;
  localparam int unsigned CFG_TX_PAR_POL = 12;
  localparam int unsigned CFG_TX_RATE = 13;
  localparam int unsigned CFG_RX2_RATE = 14;
  localparam int unsigned CFG_FORMAT = 15;
  localparam logic [15:0] CFG_RESET = 16'h0000;

  // fifo condition word bit positions
  localparam int unsigned ST_RX1_DATA = 0;
  localparam int unsigned ST_RX1_HALF = 1;
  localparam int unsigned ST_RX1_FULL = 2;
  localparam int unsigned ST_RX2_DATA = 3;
  localparam int unsigned ST_RX2_HALF = 4;
  localparam int unsigned ST_RX2_FULL = 5;
  localparam int unsigned ST_TX_EMPTY = 6;
  localparam int unsigned ST_TX_FULL = 7;
  localparam int unsigned ST_TX_HALF = 8;
  localparam logic [8:0] STATUS_RESET = 9'h040;

  // fifo levels
  localparam logic [5:0] FIFO_DEPTH = 6'h20;
  localparam logic [5:0] HALF_LEVEL = 6'h10;

  // rate dividers from the master clock
  localparam logic [6:0] DIV_FAST = 7'h0a;
  localparam logic [6:0] DIV_SLOW = 7'h50;

  // transmitter output slopes in ns, reported to the line driver only
  localparam int unsigned SLOPE_FAST_NS = 1500;
  localparam int unsigned SLOPE_SLOW_NS = 10000;

endpackage

//--- src/ath_bus_map.sv
// maps a 32-bit serial word to and from the two 16-bit host bus halves
`timescale 1ns/1ns
module ath_bus_map (
  input wire logic unscrambled,
  input wire logic [ath_pkg::WORD_W-1:0] word_in,
  output logic [ath_pkg::BUS_W-1:0] half_one,
  output logic [ath_pkg::BUS_W-1:0] half_two,
  input wire logic [ath_pkg::BUS_W-1:0] wr_half_one,
  input wire logic [ath_pkg::BUS_W-1:0] wr_half_two,
  output logic [ath_pkg::WORD_W-1:0] word_out
);
  import ath_pkg::*;

  // index k holds serial bit k+1; label bits sit in the low byte either way
  always_comb begin
    if (unscrambled) begin
      half_one = word_in[15:0];
      half_two = word_in[31:16];
      word_out = {wr_half_two, wr_half_one};
    end else begin
      half_one = {word_in[12:8], word_in[30], word_in[29], word_in[31], word_in[7:0]};
      half_two = word_in[28:13];
      word_out = {wr_half_one[8], wr_half_one[10], wr_half_one[9], wr_half_two,
                  wr_half_one[15:11], wr_half_one[7:0]};
    end
  end

endmodule

//--- src/ath_ctrl_status.sv
// configuration word and fifo condition word of the dual receiver terminal
//
// How it works
// - write strobe low loads all sixteen config bits
// - read strobe low, half select high: config out
// - receiver rate bits pick clock over 10 or 80
// - label memory bit switches strobes to labels
// - config bits 2,3 enable label matching
// - parity enable: bit 32 parity, else data
// - polarity bit: 0 odd parity, 1 even
// - loopback bit low routes transmitter into receivers
// - receiver one checks bits 9,10 against config
// - receiver two checks bits 9,10 against config
// - transmitter rate bit picks 10 or 80
// - format bit selects scrambled or plain mapping
// - read strobe low, half select low: status out
// - status read drives upper bus lines zero
// - data ready bits set while fifo not empty
// - half full bits set at sixteen words
// - full bits set when receiver fifo full
// - transmit empty bit set when fifo empty
// - transmit full bit and inverted pin
// - transmit half bit and inverted pin
`timescale 1ns/1ns
module ath_ctrl_status (
  input wire logic clk,
  input wire logic rst,
  input wire logic master_reset_n,
  input wire logic config_write_strobe_n,
  input wire logic register_read_strobe_n,
  input wire logic half_select,
  input wire logic [ath_pkg::BUS_W-1:0] host_data_lines_in,
  output logic [ath_pkg::BUS_W-1:0] host_data_lines_out,
  output logic host_data_lines_oe,
  input wire logic [ath_pkg::LVL_W-1:0] rx_one_level,
  input wire logic [ath_pkg::LVL_W-1:0] rx_two_level,
  input wire logic [ath_pkg::LVL_W-1:0] tx_level,
  output logic fifo_clear,
  output logic rx_one_ready_pin_n,
  output logic rx_one_halfway_pin_n,
  output logic rx_one_full_pin_n,
  output logic rx_two_ready_pin_n,
  output logic rx_two_halfway_pin_n,
  output logic rx_two_full_pin_n,
  output logic tx_full_pin_n,
  output logic tx_halfway_pin_n,
  output logic rx_one_rate_tick,
  output logic rx_two_rate_tick,
  output logic tx_rate_tick,
  output logic tx_slow_slope,
  output logic label_memory_access,
  input wire logic rx_one_word_done,
  input wire logic rx_one_label_hit,
  input wire logic [1:0] rx_one_bit9_10,
  output logic rx_one_load,
  input wire logic rx_two_word_done,
  input wire logic rx_two_label_hit,
  input wire logic [1:0] rx_two_bit9_10,
  output logic rx_two_load,
  input wire logic [ath_pkg::WORD_W-2:0] tx_word_body,
  input wire logic tx_bit32_in,
  output logic tx_bit32,
  input wire logic [1:0] tx_serial,
  input wire logic [1:0] rx_one_line,
  input wire logic [1:0] rx_two_line,
  output logic [1:0] rx_one_logic,
  output logic [1:0] rx_two_logic,
  input wire logic [ath_pkg::WORD_W-1:0] rx_word,
  output logic [ath_pkg::BUS_W-1:0] rx_bus_half_one,
  output logic [ath_pkg::BUS_W-1:0] rx_bus_half_two,
  input wire logic [ath_pkg::BUS_W-1:0] tx_bus_half_one,
  input wire logic [ath_pkg::BUS_W-1:0] tx_bus_half_two,
  output logic [ath_pkg::WORD_W-1:0] tx_word_assembled
);
  import ath_pkg::*;

  typedef struct packed {
    logic [SYNC_N-1:0] wr_sync;
    logic [SYNC_N-1:0] rd_sync;
    logic [SYNC_N-1:0] sel_sync;
    logic [SYNC_N-1:0] mr_sync;
    logic [SYNC_N-1:0][BUS_W-1:0] data_sync;
    logic wr_lvl;
    logic rd_lvl;
    logic sel_lvl;
    logic mr_lvl;
    logic [BUS_W-1:0] cfg;
    logic [STAT_W-1:0] status;
    logic [BUS_W-1:0] bus_out;
    logic bus_oe;
    logic [2:0][DIV_W-1:0] div_cnt;
    logic [2:0] tick;
    logic [7:0] pins_n;
    logic fifo_clear;
    logic slow_slope;
    logic label_mem;
    logic rx1_load;
    logic rx2_load;
    logic bit32;
    logic [1:0] rx1_logic;
    logic [1:0] rx2_logic;
    logic [BUS_W-1:0] map_one;
    logic [BUS_W-1:0] map_two;
    logic [WORD_W-1:0] tx_word;
  } ath_state_t;

  ath_state_t st;
  ath_state_t next_st;
  logic [BUS_W-1:0] map_one_c;
  logic [BUS_W-1:0] map_two_c;
  logic [WORD_W-1:0] tx_word_c;
  logic wr_fall;
  logic [2:0] rate_sel;

  ath_bus_map u_map (
    .unscrambled(st.cfg[CFG_FORMAT]),
    .word_in(rx_word),
    .half_one(map_one_c),
    .half_two(map_two_c),
    .wr_half_one(tx_bus_half_one),
    .wr_half_two(tx_bus_half_two),
    .word_out(tx_word_c)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  // a pin level counts once the second and third stages agree
  assign wr_fall = (st.wr_sync[1] == st.wr_sync[2]) && !st.wr_sync[2] && st.wr_lvl;
  assign rate_sel = {st.cfg[CFG_TX_RATE], st.cfg[CFG_RX2_RATE], st.cfg[CFG_RX1_RATE]};

  always_comb begin
    logic [DIV_W-1:0] lim;
    logic fifo_ok1;
    logic fifo_ok2;
    lim = DIV_FAST;
    fifo_ok1 = 1'b0;
    fifo_ok2 = 1'b0;
    next_st = st;

    next_st.wr_sync = {st.wr_sync[1:0], config_write_strobe_n};
    next_st.rd_sync = {st.rd_sync[1:0], register_read_strobe_n};
    next_st.sel_sync = {st.sel_sync[1:0], half_select};
    next_st.mr_sync = {st.mr_sync[1:0], master_reset_n};
    next_st.data_sync = {st.data_sync[1:0], host_data_lines_in};
    if (st.wr_sync[1] == st.wr_sync[2]) begin
      next_st.wr_lvl = st.wr_sync[2];
    end
    if (st.rd_sync[1] == st.rd_sync[2]) begin
      next_st.rd_lvl = st.rd_sync[2];
    end
    if (st.sel_sync[1] == st.sel_sync[2]) begin
      next_st.sel_lvl = st.sel_sync[2];
    end
    if (st.mr_sync[1] == st.mr_sync[2]) begin
      next_st.mr_lvl = st.mr_sync[2];
    end

    // data passed the same three stages, so it lines up with the strobe edge
    if (wr_fall) begin
      next_st.cfg = st.data_sync[2];
    end

    // read path: bus is driven for as long as the read strobe stays low
    next_st.bus_oe = !st.rd_lvl;
    if (st.sel_lvl) begin
      next_st.bus_out = st.cfg;
    end else begin
      next_st.bus_out = {{(BUS_W-STAT_W){1'b0}}, st.status};
    end

    // fifo condition word, held at its cleared image during master reset
    next_st.fifo_clear = !st.mr_lvl;
    if (!st.mr_lvl) begin
      next_st.status = STATUS_RESET;
    end else begin
      next_st.status[ST_RX1_DATA] = rx_one_level != 6'h00;
      next_st.status[ST_RX1_HALF] = rx_one_level >= HALF_LEVEL;
      next_st.status[ST_RX1_FULL] = rx_one_level >= FIFO_DEPTH;
      next_st.status[ST_RX2_DATA] = rx_two_level != 6'h00;
      next_st.status[ST_RX2_HALF] = rx_two_level >= HALF_LEVEL;
      next_st.status[ST_RX2_FULL] = rx_two_level >= FIFO_DEPTH;
      next_st.status[ST_TX_EMPTY] = tx_level == 6'h00;
      next_st.status[ST_TX_FULL] = tx_level >= FIFO_DEPTH;
      next_st.status[ST_TX_HALF] = tx_level >= HALF_LEVEL;
    end
    // pins follow the status word in the same cycle, inverted
    next_st.pins_n = ~{next_st.status[ST_TX_HALF], next_st.status[ST_TX_FULL],
                       next_st.status[ST_RX2_FULL], next_st.status[ST_RX2_HALF],
                       next_st.status[ST_RX2_DATA], next_st.status[ST_RX1_FULL],
                       next_st.status[ST_RX1_HALF], next_st.status[ST_RX1_DATA]};

    // rate enables for receiver one, receiver two and transmitter
    for (int i = 0; i < 3; i++) begin
      lim = rate_sel[i] ? DIV_SLOW : DIV_FAST;
      // >= keeps a shortened limit from stranding the counter after a rate change
      if (st.div_cnt[i] >= lim - 7'h01) begin
        next_st.div_cnt[i] = 7'h00;
        next_st.tick[i] = 1'b1;
      end else begin
        next_st.div_cnt[i] = st.div_cnt[i] + 7'h01;
        next_st.tick[i] = 1'b0;
      end
    end
    next_st.slow_slope = st.cfg[CFG_TX_RATE];
    next_st.label_mem = st.cfg[CFG_LABEL_MEM];

    // word acceptance: label match and bits 9,10 check both must pass
    fifo_ok1 = (!st.cfg[CFG_RX1_LABEL_EN] || rx_one_label_hit) &&
               (!st.cfg[CFG_RX1_DEC_EN] ||
                rx_one_bit9_10 == {st.cfg[CFG_RX1_BIT10], st.cfg[CFG_RX1_BIT9]});
    fifo_ok2 = (!st.cfg[CFG_RX2_LABEL_EN] || rx_two_label_hit) &&
               (!st.cfg[CFG_RX2_DEC_EN] ||
                rx_two_bit9_10 == {st.cfg[CFG_RX2_BIT10], st.cfg[CFG_RX2_BIT9]});
    // label memory mode takes the strobes, so no received word is stored then
    next_st.rx1_load = rx_one_word_done && fifo_ok1 && !st.cfg[CFG_LABEL_MEM];
    next_st.rx2_load = rx_two_word_done && fifo_ok2 && !st.cfg[CFG_LABEL_MEM];

    // 32nd transmitted bit
    if (st.cfg[CFG_TX_PARITY_EN]) begin
      next_st.bit32 = st.cfg[CFG_TX_PAR_POL] ^ ~(^tx_word_body);
    end else begin
      next_st.bit32 = tx_bit32_in;
    end

    // self test loopback, active low
    if (!st.cfg[CFG_LOOPBACK_N]) begin
      next_st.rx1_logic = tx_serial;
      next_st.rx2_logic = tx_serial;
    end else begin
      next_st.rx1_logic = rx_one_line;
      next_st.rx2_logic = rx_two_line;
    end

    next_st.map_one = map_one_c;
    next_st.map_two = map_two_c;
    next_st.tx_word = tx_word_c;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
      st.wr_sync <= 3'h7;
      st.rd_sync <= 3'h7;
      st.mr_sync <= 3'h7;
      st.wr_lvl <= 1'b1;
      st.rd_lvl <= 1'b1;
      st.mr_lvl <= 1'b1;
      st.cfg <= CFG_RESET;
      st.status <= STATUS_RESET;
      st.pins_n <= 8'hff;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign host_data_lines_out = st.bus_out;
  assign host_data_lines_oe = st.bus_oe;
  assign fifo_clear = st.fifo_clear;
  assign rx_one_ready_pin_n = st.pins_n[0];
  assign rx_one_halfway_pin_n = st.pins_n[1];
  assign rx_one_full_pin_n = st.pins_n[2];
  assign rx_two_ready_pin_n = st.pins_n[3];
  assign rx_two_halfway_pin_n = st.pins_n[4];
  assign rx_two_full_pin_n = st.pins_n[5];
  assign tx_full_pin_n = st.pins_n[6];
  assign tx_halfway_pin_n = st.pins_n[7];
  assign rx_one_rate_tick = st.tick[0];
  assign rx_two_rate_tick = st.tick[1];
  assign tx_rate_tick = st.tick[2];
  assign tx_slow_slope = st.slow_slope;
  assign label_memory_access = st.label_mem;
  assign rx_one_load = st.rx1_load;
  assign rx_two_load = st.rx2_load;
  assign tx_bit32 = st.bit32;
  assign rx_one_logic = st.rx1_logic;
  assign rx_two_logic = st.rx2_logic;
  assign rx_bus_half_one = st.map_one;
  assign rx_bus_half_two = st.map_two;
  assign tx_word_assembled = st.tx_word;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_cfg_read;
    !st.rd_lvl && st.sel_lvl;
  endsequence

  sequence s_stat_read;
    !st.rd_lvl && !st.sel_lvl;
  endsequence

  sequence s_fast_period;
    st.tick[0] && !st.cfg[CFG_RX1_RATE] ##1 !st.cfg[CFG_RX1_RATE] [*8]
      ##1 !st.cfg[CFG_RX1_RATE];
  endsequence

  a_cfg_capture: assert property (wr_fall |=> st.cfg == $past(st.data_sync[2]))
    else $error("config word not loaded on write strobe");

  a_cfg_readback: assert property (s_cfg_read |=> st.bus_oe && st.bus_out == $past(st.cfg))
    else $error("config word not driven on read");

  a_status_read: assert property (s_stat_read |=> st.bus_oe && st.bus_out[15:9] == 7'h00
                                  && st.bus_out[8:0] == $past(st.status))
    else $error("status word not driven on read");

  a_rx_fast_rate: assert property (s_fast_period |=> st.tick[0])
    else $error("receiver one fast rate period wrong");

  a_tx_slow_gap: assert property (st.tick[2] && st.cfg[CFG_TX_RATE] |=> !st.tick[2] [*8])
    else $error("transmitter slow rate tick too soon");

  a_parity_value: assert property (st.cfg[CFG_TX_PARITY_EN] |=>
                                   (^{st.bit32, $past(tx_word_body)}) == !$past(st.cfg[CFG_TX_PAR_POL]))
    else $error("transmitted parity wrong");

  a_bit32_data: assert property (!st.cfg[CFG_TX_PARITY_EN] |=> st.bit32 == $past(tx_bit32_in))
    else $error("32nd bit not host data");

  a_loopback_route: assert property (!st.cfg[CFG_LOOPBACK_N] |=> st.rx1_logic == $past(tx_serial)
                                     && st.rx2_logic == $past(tx_serial))
    else $error("loopback not routed");

  a_rx1_decode: assert property (rx_one_word_done && st.cfg[CFG_RX1_DEC_EN] &&
                                 rx_one_bit9_10 != {st.cfg[CFG_RX1_BIT10], st.cfg[CFG_RX1_BIT9]}
                                 |=> !st.rx1_load)
    else $error("receiver one loaded a mismatched word");

  a_rx2_label: assert property (rx_two_word_done && st.cfg[CFG_RX2_LABEL_EN] && !rx_two_label_hit
                                |=> !st.rx2_load)
    else $error("receiver two loaded an unmatched label");

  a_half_level: assert property (st.mr_lvl |=> st.status[ST_RX1_HALF] == ($past(rx_one_level) >= HALF_LEVEL)
                                 && st.pins_n[1] == !st.status[ST_RX1_HALF])
    else $error("receiver one half flag wrong");

  a_tx_flags: assert property (st.mr_lvl |=> st.status[ST_TX_EMPTY] == ($past(tx_level) == 6'h00)
                               && st.pins_n[6] == !st.status[ST_TX_FULL])
    else $error("transmit fifo flags wrong");

  a_reset_image: assert property (!st.mr_lvl |=> st.status == STATUS_RESET && st.fifo_clear)
    else $error("master reset status image wrong");

endmodule

//--- tb/ath_host_model.sv
// host processor model: strobed config writes and register reads
`timescale 1ns/1ns
module ath_host_model (
  input wire logic clk,
  input wire logic [15:0] bus_out,
  input wire logic bus_oe,
  output logic [15:0] data_drv,
  output logic wr_n,
  output logic rd_n,
  output logic sel
);
  initial begin
    data_drv = 16'h0000;
    wr_n = 1'b1;
    rd_n = 1'b1;
    sel = 1'b0;
  end
  ////////////////////////////////////////
  // data is held well past the strobe because the device samples it late
  task automatic cfg_write(input logic [15:0] d);
    @(negedge clk);
    data_drv = d;
    wr_n = 1'b0;
    repeat (5) @(negedge clk);
    wr_n = 1'b1;
    repeat (4) @(negedge clk);
    // released lines show the inverse so a stale copy cannot pass
    data_drv = ~d;
  endtask
  task automatic reg_read(input logic s, output logic [15:0] d, output logic ok);
    int n;
    @(negedge clk);
    sel = s;
    repeat (5) @(negedge clk);
    rd_n = 1'b0;
    for (n = 0; n < 12 && bus_oe !== 1'b1; n++) @(negedge clk);
    ok = n < 12;
    d = bus_out;
    rd_n = 1'b1;
    for (n = 0; n < 12 && bus_oe !== 1'b0; n++) @(negedge clk);
    ok = ok && n < 12;
  endtask
endmodule

//--- tb/test_arinc_terminal_ctrl_status_regs.sv
// self-checking bench for the terminal configuration and status registers
`timescale 1ns/1ns
module test_arinc_terminal_ctrl_status_regs;
  import ath_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic mr_n = 1'b1;
  logic oe, fclr, tick1, tick2, tickt, slope, lma, ld1, ld2, b32, wd1, wd2, hit1, hit2, b32i;
  logic wr_n, rd_n, sel;
  logic [15:0] drv, dout, h1, h2, th1, th2;
  logic [5:0] lv1, lv2, lvt;
  logic [1:0] b1, b2, ser, ln1, ln2, lg1, lg2;
  logic [30:0] body;
  logic [31:0] rxw, txw, exp_tx;
  logic [8:0] st;
  wire [15:0] din = oe ? dout : drv;
  wire [7:0] pins;
  wire [2:0] ticks = {tickt, tick2, tick1};
  int err_count = 0;
  int total_checks = 0;
  int cfg;
  int lvtab[6] = '{0, 1, 15, 16, 31, 32};
  int ctab[4] = '{'hffff, 'h0000, 'h0254, 'h1000};
  int cfg_q[$];
  always #20 clk = ~clk;
  ath_ctrl_status DUT (
    .clk(clk), .rst(rst), .master_reset_n(mr_n), .config_write_strobe_n(wr_n),
    .register_read_strobe_n(rd_n), .half_select(sel), .host_data_lines_in(din),
    .host_data_lines_out(dout), .host_data_lines_oe(oe), .rx_one_level(lv1),
    .rx_two_level(lv2), .tx_level(lvt), .fifo_clear(fclr),
    .rx_one_ready_pin_n(pins[0]), .rx_one_halfway_pin_n(pins[1]), .rx_one_full_pin_n(pins[2]),
    .rx_two_ready_pin_n(pins[3]), .rx_two_halfway_pin_n(pins[4]), .rx_two_full_pin_n(pins[5]),
    .tx_full_pin_n(pins[6]), .tx_halfway_pin_n(pins[7]), .rx_one_rate_tick(tick1),
    .rx_two_rate_tick(tick2), .tx_rate_tick(tickt), .tx_slow_slope(slope),
    .label_memory_access(lma), .rx_one_word_done(wd1), .rx_one_label_hit(hit1),
    .rx_one_bit9_10(b1), .rx_one_load(ld1), .rx_two_word_done(wd2),
    .rx_two_label_hit(hit2), .rx_two_bit9_10(b2), .rx_two_load(ld2),
    .tx_word_body(body), .tx_bit32_in(b32i), .tx_bit32(b32), .tx_serial(ser),
    .rx_one_line(ln1), .rx_two_line(ln2), .rx_one_logic(lg1), .rx_two_logic(lg2),
    .rx_word(rxw), .rx_bus_half_one(h1), .rx_bus_half_two(h2), .tx_bus_half_one(th1),
    .tx_bus_half_two(th2), .tx_word_assembled(txw)
  );
  ath_host_model host (
    .clk(clk), .bus_out(dout), .bus_oe(oe), .data_drv(drv), .wr_n(wr_n), .rd_n(rd_n),
    .sel(sel)
  );
  ////////////////////////////////////////
  function automatic logic [8:0] exp_status(int a, int b, int c);
    return {c >= 16, c >= 32, c == 0, b >= 32, b >= 16, b != 0, a >= 32, a >= 16, a != 0};
  endfunction
  // returns {half two, half one} for a serial word
  function automatic logic [31:0] mapw(logic [31:0] w, logic u);
    return u ? w : {w[28:13], w[12:8], w[30], w[29], w[31], w[7:0]};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      $display("[FAIL] %0t %s", $time, msg);
      err_count++;
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic rd_chk(input logic s, input logic [15:0] e, input string msg);
    logic [15:0] d;
    logic ok;
    host.reg_read(s, d, ok);
    if (!ok) begin
      err_count++;
      complete_run();
    end else begin
      check(d, e, msg);
    end
  endtask
  // waits for one tick, then counts to the next so the period is exact
  task automatic period(input int k, input int e);
    int n;
    int m;
    for (n = 0; n < 200 && ticks[k] !== 1'b1; n++) @(negedge clk);
    @(negedge clk);
    for (m = 1; m < 200 && ticks[k] !== 1'b1; m++) @(negedge clk);
    if (n >= 200 || m >= 200) begin
      err_count++;
      complete_run();
    end
    check(m, e, "tick period");
  endtask
  task automatic rnd_inputs();
    logic [31:0] tw;
    body = 31'($urandom);
    b32i = 1'($urandom);
    {ser, ln1, ln2} = 6'($urandom);
    rxw = $urandom;
    tw = $urandom;
    {th2, th1} = mapw(tw, cfg[15]);
    exp_tx = tw;
  endtask
  // load lands one cycle after the pulse; the cycle after that is sampled as well
  task automatic accept_case();
    logic [1:0] got, e;
    {hit1, hit2, b1, b2} = 6'($urandom);
    wd1 = 1'b1;
    wd2 = 1'b1;
    // label memory mode owns the strobes, so nothing is stored then
    e[0] = (!cfg[2] || hit1) && (!cfg[6] || b1 == {cfg[8], cfg[7]}) && !cfg[1];
    e[1] = (!cfg[3] || hit2) && (!cfg[9] || b2 == {cfg[11], cfg[10]}) && !cfg[1];
    @(negedge clk);
    {wd1, wd2} = 2'b00;
    got = {ld2, ld1};
    @(negedge clk);
    got = got | {ld2, ld1};
    check(got, e, "word accept");
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    complete_run();
  end
  initial begin
    void'($urandom(32'h36b2));
    {wd1, wd2, hit1, hit2, b32i, b1, b2, ser, ln1, ln2, lv1, lv2, lvt} = '0;
    {body, rxw, th1, th2} = '0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check(pins, 8'hff, "pins after reset");
    rd_chk(1'b0, 16'(STATUS_RESET), "status after reset");
    rd_chk(1'b1, CFG_RESET, "config after reset");
    for (int i = 0; i < 10; i++) begin
      cfg = i < 4 ? ctab[i] : $urandom_range(16'hffff);
      cfg_q.push_back(cfg);
      host.cfg_write(16'(cfg));
      rd_chk(1'b1, 16'(cfg_q.pop_front()), "config readback");
      check({lma, slope}, {cfg[1], cfg[13]}, "config outputs");
      if (i < 2) begin
        period(0, cfg[0] ? 80 : 10);
        period(1, cfg[14] ? 80 : 10);
        period(2, cfg[13] ? 80 : 10);
      end
      rnd_inputs();
      repeat (3) @(negedge clk);
      check(b32, cfg[4] ? (^body) ^ !cfg[12] : b32i, "bit 32");
      check({lg2, lg1}, cfg[5] ? {ln2, ln1} : {ser, ser}, "receiver inputs");
      check({h2, h1}, mapw(rxw, cfg[15]), "receive halves");
      check(txw, exp_tx, "transmit word");
      repeat (4) accept_case();
    end
    for (int i = 0; i < 12; i++) begin
      // levels are set from the table before each status poll; receiver two's entry is picked at random
      lv1 = 6'(lvtab[i % 6]);
      lv2 = 6'(lvtab[$urandom_range(5)]);
      lvt = 6'(lvtab[(i + 3) % 6]);
      st = exp_status(lv1, lv2, lvt);
      rd_chk(1'b0, {7'h00, st}, "status word");
      check(pins, 8'(~{st[8:7], st[5:0]}), "flag pins");
    end
    {lv1, lv2, lvt} = '0;
    mr_n = 1'b0;
    repeat (6) @(negedge clk);
    check({fclr, pins}, 9'h1ff, "master reset");
    mr_n = 1'b1;
    repeat (6) @(negedge clk);
    check(fclr, 1'b0, "master reset release");
    // second reset in mid-run must drop the stored word back to its reset value
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    check({lma, slope, ld1, ld2}, 4'h0, "outputs after second reset");
    rd_chk(1'b1, CFG_RESET, "config after second reset");
    complete_run();
  end
endmodule
